// file: rtl/ptt_pkg.sv
package ptt_pkg;

  // ==========================================================
  // widths
  localparam int unsigned PTT_ADDR_W = 8;
  localparam int unsigned PTT_DATA_W = 32;
  localparam int unsigned PTT_CNT_W = 16;
  localparam int unsigned PTT_SEL_W = 3;
  localparam int unsigned PTT_DIV_W = 5;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] PTT_OFS_RELOAD = 8'h00;
  localparam logic [7:0] PTT_OFS_CTRL = 8'h04;
  localparam logic [7:0] PTT_OFS_PRESCALE = 8'h08;
  localparam logic [7:0] PTT_OFS_LOCK = 8'h0c;
  localparam logic [7:0] PTT_OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] PTT_OFS_IRQ_MASK = 8'h14;

  // ==========================================================
  // field positions
  localparam int unsigned PTT_CTRL_IEN_BIT = 0;
  localparam int unsigned PTT_CTRL_RST_BIT = 1;
  localparam int unsigned PTT_CTRL_TC_BIT = 2;
  localparam int unsigned PTT_LOCK_BIT = 0;
  localparam int unsigned PTT_IRQ_TICK_BIT = 0;

  // ==========================================================
  // reset values and prescale select limit
  localparam logic [15:0] PTT_RELOAD_RST = 16'hffff;
  localparam logic [2:0] PTT_SEL_RST = 3'h0;
  localparam logic [2:0] PTT_SEL_MAX = 3'h5;

  typedef struct packed {
    logic tc;
    logic restart;
    logic ien;
  } ptt_ctrl_t;

  localparam ptt_ctrl_t PTT_CTRL_RST = '{tc: 1'b0, restart: 1'b0, ien: 1'b0};

endpackage

// file: rtl/ptt_prescaler.sv
`timescale 1ns/1ps
module ptt_prescaler
  import ptt_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow_edge,
  input wire logic [PTT_SEL_W-1:0] prescale_select,
  output logic tick_en
);

  logic [PTT_DIV_W-1:0] div_reg;
  logic [PTT_DIV_W-1:0] div_mask;

  // ==========================================================
  // power-of-two divider
  // divisor 2^sel: tick when the low sel bits are all ones
  assign div_mask = PTT_DIV_W'((1 << prescale_select) - 1);
  assign tick_en = slow_edge && ((div_reg & div_mask) == div_mask);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      div_reg <= '0;
    end else if (slow_edge) begin
      div_reg <= div_reg + 1'b1;
    end
  end

  divide_by_one_a: assert property (@(posedge ref_clk) disable iff (reset)
    (prescale_select == 3'h0) |-> (tick_en == slow_edge))
    else $error("divide by one does not follow slow clock");

endmodule // ptt_prescaler

// file: rtl/ptt_tick_timer.sv
// Implementation choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
module ptt_tick_timer
  import ptt_pkg::*;
#(
  parameter int unsigned CNT_W = PTT_CNT_W
)
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic slow_clock_source,
  input wire logic [PTT_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [PTT_DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [PTT_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic prescaled_tick_clock,
  output logic tick_terminal_pulse,
  output logic wakeup_tick_pulse,
  output logic tick_irq_line
);

  if (CNT_W != PTT_CNT_W) begin : g_bad_width
    $error("counter width must be 16");
  end

  // ==========================================================
  // declarations
  logic slow_prev_reg;
  logic slow_edge;
  logic tick_en;
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic [CNT_W-1:0] reload_reg;
  logic [PTT_SEL_W-1:0] sel_reg;
  ptt_ctrl_t ctrl_reg;
  logic lock_reg;
  logic irq_stat_reg;
  logic irq_mask_reg;
  logic hit;
  logic wait_reg;
  logic [PTT_DATA_W-1:0] rdata_reg;
  logic tick_out_reg;
  logic pulse_reg;
  logic wake_reg;
  logic irq_reg;

  logic req;
  logic acc;
  logic wr_acc;
  logic sel_reload;
  logic sel_ctrl;
  logic sel_pre;
  logic sel_lock;
  logic sel_stat;
  logic sel_mask;
  logic [PTT_DATA_W-1:0] lane_mask;
  logic [PTT_DATA_W-1:0] wd_m;
  logic [PTT_DATA_W-1:0] rdata_next;
  logic wr_reload;
  logic wr_ctrl;
  logic wr_pre;
  logic [PTT_SEL_W-1:0] sel_wr_val;
  logic restart_set;
  logic tc_clr;
  logic stat_clr;
  logic irq_next;

  function automatic logic [PTT_DATA_W-1:0] merge(input logic [PTT_DATA_W-1:0] old,
                                                  input logic [PTT_DATA_W-1:0] wd,
                                                  input logic [PTT_DATA_W-1:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // ==========================================================
  // slow clock edge and prescaler
  // slow clock is taken as synchronous, so a plain edge detect suffices
  assign slow_edge = slow_clock_source && !slow_prev_reg;

  ptt_prescaler u_prescaler (
    .ref_clk(ref_clk),
    .reset(reset),
    .slow_edge(slow_edge),
    .prescale_select(sel_reg),
    .tick_en(tick_en)
  );

  // ==========================================================
  // bus decode
  assign req = avs_read || avs_write;
  assign acc = req && !wait_reg;
  assign wr_acc = acc && avs_write;
  assign sel_reload = (avs_address == PTT_OFS_RELOAD);
  assign sel_ctrl = (avs_address == PTT_OFS_CTRL);
  assign sel_pre = (avs_address == PTT_OFS_PRESCALE);
  assign sel_lock = (avs_address == PTT_OFS_LOCK);
  assign sel_stat = (avs_address == PTT_OFS_IRQ_STAT);
  assign sel_mask = (avs_address == PTT_OFS_IRQ_MASK);
  for (genvar i = 0; i < 4; i++) begin : g_lane
    assign lane_mask[8*i +: 8] = {8{avs_byteenable[i]}};
  end
  assign wd_m = avs_writedata & lane_mask;

  // locked reload, control and prescale: writes dropped
  assign wr_reload = wr_acc && sel_reload && !lock_reg;
  assign wr_ctrl = wr_acc && sel_ctrl && !lock_reg;
  assign wr_pre = wr_acc && sel_pre && !lock_reg && avs_byteenable[0];
  assign sel_wr_val = avs_writedata[PTT_SEL_W-1:0];
  assign restart_set = wr_ctrl && wd_m[PTT_CTRL_RST_BIT];
  assign tc_clr = wr_ctrl && wd_m[PTT_CTRL_TC_BIT];
  assign stat_clr = wr_acc && sel_stat && wd_m[PTT_IRQ_TICK_BIT];

  // locked reload and control registers read back as zero; the locked prescale still reads back its value
  assign rdata_next =
    (sel_reload && !lock_reg) ? PTT_DATA_W'(reload_reg) :
    (sel_ctrl && !lock_reg) ? PTT_DATA_W'(ctrl_reg) :
    sel_pre ? PTT_DATA_W'(sel_reg) :
    sel_lock ? PTT_DATA_W'(lock_reg) :
    sel_stat ? PTT_DATA_W'(irq_stat_reg) :
    sel_mask ? PTT_DATA_W'(irq_mask_reg) : '0;

  // ==========================================================
  // counter datapath
  // restart wins over the natural step; reload only read here, so
  // a reload written mid-run is picked up at the next zero
  assign count_next = ctrl_reg.restart ? reload_reg :
                      (count_reg == '0) ? reload_reg :
                      count_reg - 1'b1;
  assign hit = tick_en && (count_next == '0);
  assign irq_next = irq_stat_reg && irq_mask_reg && ctrl_reg.ien;

  // ==========================================================
  // bus slave: one wait cycle, then answer
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      wait_reg <= 1'b1;
      rdata_reg <= '0;
    end else begin
      wait_reg <= !(req && wait_reg);
      if (req && wait_reg) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      reload_reg <= PTT_RELOAD_RST;
      sel_reg <= PTT_SEL_RST;
      lock_reg <= 1'b0;
      irq_mask_reg <= 1'b0;
    end else begin
      if (wr_reload) begin
        reload_reg <= CNT_W'(merge(PTT_DATA_W'(reload_reg), wd_m, lane_mask));
      end
      // reserved codes leave the divisor unchanged
      if (wr_pre && sel_wr_val <= PTT_SEL_MAX) begin
        sel_reg <= sel_wr_val;
      end
      if (wr_acc && sel_lock && wd_m[PTT_LOCK_BIT]) begin
        lock_reg <= 1'b1;
      end
      if (wr_acc && sel_mask && avs_byteenable[0]) begin
        irq_mask_reg <= avs_writedata[PTT_IRQ_TICK_BIT];
      end
    end
  end

  // ==========================================================
  // control, flags, counter
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_reg <= PTT_CTRL_RST;
      irq_stat_reg <= 1'b0;
      count_reg <= PTT_RELOAD_RST;
      // held high, so a pin already high at release is not an edge
      slow_prev_reg <= 1'b1;
    end else begin
      slow_prev_reg <= slow_clock_source;
      if (tick_en) begin
        count_reg <= count_next;
      end
      if (wr_ctrl && avs_byteenable[0]) begin
        ctrl_reg.ien <= avs_writedata[PTT_CTRL_IEN_BIT];
      end
      // a fresh request in the consuming cycle survives
      ctrl_reg.restart <= restart_set || (ctrl_reg.restart && !tick_en);
      // set wins over clear
      ctrl_reg.tc <= hit || (ctrl_reg.tc && !tc_clr);
      irq_stat_reg <= hit || (irq_stat_reg && !stat_clr);
    end
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tick_out_reg <= 1'b0;
      pulse_reg <= 1'b0;
      wake_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      tick_out_reg <= tick_en;
      if (tick_en) begin
        pulse_reg <= hit;
        wake_reg <= hit;
      end
      irq_reg <= irq_next;
    end
  end

  assign avs_waitrequest = wait_reg;
  assign avs_readdata = rdata_reg;
  assign prescaled_tick_clock = tick_out_reg;
  assign tick_terminal_pulse = pulse_reg;
  assign wakeup_tick_pulse = wake_reg;
  assign tick_irq_line = irq_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  count_step_a: assert property (
    (tick_en && !ctrl_reg.restart && count_reg != '0) |=> (count_reg == $past(count_reg) - 1'b1))
    else $error("counter did not step down by one");

  auto_reload_a: assert property (
    (tick_en && !ctrl_reg.restart && count_reg == '0) |=> (count_reg == $past(reload_reg)))
    else $error("counter did not reload at zero");

  pulse_start_a: assert property (
    hit |=> (tick_terminal_pulse && wakeup_tick_pulse))
    else $error("terminal pulse not raised on zero");

  pulse_width_a: assert property (
    (tick_terminal_pulse && !tick_en) |=> tick_terminal_pulse)
    else $error("terminal pulse dropped before next tick");

  tc_flag_set_a: assert property (
    hit |=> ctrl_reg.tc)
    else $error("terminal count flag not set");

  irq_raise_a: assert property (
    (hit && irq_mask_reg && ctrl_reg.ien) ##1 (ctrl_reg.ien && irq_mask_reg) |=> tick_irq_line)
    else $error("tick interrupt not raised");

  irq_gate_a: assert property (
    !ctrl_reg.ien |=> !tick_irq_line)
    else $error("tick interrupt raised while disabled");

  restart_load_a: assert property (
    (tick_en && ctrl_reg.restart) |=> (count_reg == $past(reload_reg)))
    else $error("restart did not reload the counter");

  restart_clear_a: assert property (
    (tick_en && ctrl_reg.restart && !restart_set) |=> !ctrl_reg.restart)
    else $error("restart request not cleared");

  lock_hold_a: assert property (
    lock_reg |=> (lock_reg && $stable(sel_reg)))
    else $error("lock or prescale changed while locked");

  locked_write_a: assert property (
    lock_reg |=> ($stable(reload_reg) && $stable(ctrl_reg.ien)))
    else $error("locked register was written");

  count_idle_a: assert property (
    !tick_en |=> $stable(count_reg))
    else $error("counter moved without a tick");

  pulse_end_a: assert property (
    (tick_en && !hit) |=> !tick_terminal_pulse)
    else $error("terminal pulse outlived its tick");

  wake_copy_a: assert property (
    wakeup_tick_pulse == tick_terminal_pulse)
    else $error("wake-up pulse differs from terminal pulse");

  reload_defer_a: assert property (
    (wr_reload && !tick_en) |=> (count_reg == $past(count_reg)))
    else $error("reload write disturbed the running count");

  restart_take_a: assert property (
    restart_set |=> ctrl_reg.restart)
    else $error("restart request not taken");

  restart_hold_a: assert property (
    (ctrl_reg.restart && !tick_en) |=> ctrl_reg.restart)
    else $error("restart request dropped before a tick");

  reserved_code_a: assert property (
    (wr_pre && sel_wr_val > PTT_SEL_MAX) |=> $stable(sel_reg))
    else $error("reserved prescale code accepted");

  sel_range_a: assert property (
    sel_reg <= PTT_SEL_MAX)
    else $error("prescale select out of range");

  tc_sticky_a: assert property (
    (ctrl_reg.tc && !tc_clr) |=> ctrl_reg.tc)
    else $error("terminal count flag lost without clear");

endmodule // ptt_tick_timer

// file: tb/ptt_far_end.sv
`timescale 1ns/1ps
module ptt_far_end (
  input wire logic ref_clk,
  input wire logic pulse,
  input wire logic wake,
  input wire logic ptc,
  output int pulses,
  output int period,
  output int width,
  output int tpp,
  output int wake_bad
);
  int cyc = 0;
  int rise = 0;
  int tcnt = 0;
  logic prev = 1'b0;
  wire logic rise_now = pulse && !prev;

  // ==========================================================
  // wake-up and watchdog side: only listens, so outputs update by nba
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    prev <= pulse;
    tcnt <= rise_now ? int'(ptc) : tcnt + int'(ptc);
    if (rise_now) begin
      pulses <= pulses + 1;
      period <= cyc - rise;
      rise <= cyc;
      tpp <= tcnt;
    end
    if (!pulse && prev) width <= cyc - rise;
    if (wake !== pulse) wake_bad <= wake_bad + 1;
  end
endmodule // ptt_far_end

// file: tb/tb_prescaled_periodic_tick_timer.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
  $display("Error t=%0t got %0h exp %0h", $time, (a), (b)); end end
module tb_prescaled_periodic_tick_timer;
  import ptt_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic slow_clock_source = 1'b0;
  logic [1:0] sdiv = 2'h0;
  logic [PTT_ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [PTT_DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [PTT_DATA_W-1:0] avs_readdata, q;
  logic avs_waitrequest, prescaled_tick_clock, tick_terminal_pulse;
  logic wakeup_tick_pulse, tick_irq_line;
  int fails = 0;
  int n_tests = 0;
  int seed = 32'h1de4;
  int pulses, period, width, tpp, wake_bad, rl;

  ptt_tick_timer DUT (.ref_clk, .reset, .slow_clock_source, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .prescaled_tick_clock, .tick_terminal_pulse, .wakeup_tick_pulse, .tick_irq_line);
  ptt_far_end far (.ref_clk, .pulse(tick_terminal_pulse), .wake(wakeup_tick_pulse),
    .ptc(prescaled_tick_clock), .pulses, .period, .width, .tpp, .wake_bad);

  // ==========================================================
  // clocks: slow clock is ref_clk / 4 so even divisor 32 ends quickly
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    sdiv <= sdiv + 2'h1;
    slow_clock_source <= sdiv[1];
  end

  // ==========================================================
  // bus and helpers
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (n >= 100) begin
      fails++;
      $display("Error t=%0t bus handshake timed out", $time);
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, '0);
    `CHK(q, e)
  endtask

  task automatic wait_p(input int n);
    int t0, k;
    t0 = pulses;
    k = 0;
    while (pulses < t0 + n && k < 8000) begin
      @(posedge ref_clk);
      k++;
    end
    if (k >= 8000) begin
      fails++;
      $display("Error t=%0t terminal pulse missing", $time);
    end
  endtask

  // slow clock is ref_clk / 4, so one prescaled tick is 4 << code cycles
  function automatic int exp_period(input int r, input int code);
    return (r + 1) * (4 << code);
  endfunction

  task automatic final_report;
    if (fails == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rd(PTT_OFS_RELOAD, 32'h0000_ffff);
    rd(PTT_OFS_CTRL, 32'h0000_0000);
    bus(1'b1, 8'h18, 32'hffff_ffff);
    rd(8'h18, 32'h0000_0000);
    for (int c = 0; c < 6; c++) begin
      rl = 1 + int'($unsigned($random(seed)) % 3);
      bus(1'b1, PTT_OFS_PRESCALE, 32'(c));
      bus(1'b1, PTT_OFS_RELOAD, 32'(rl));
      bus(1'b1, PTT_OFS_CTRL, 32'h0000_0002);
      wait_p(3);
      `CHK(period, exp_period(rl, c))
      `CHK(width, 4 << c)
      `CHK(tpp, rl + 1)
    end
    bus(1'b1, PTT_OFS_PRESCALE, 32'h0000_0006);
    rd(PTT_OFS_PRESCALE, 32'h0000_0005);
    // new reload mid-count leaves the running count alone
    bus(1'b1, PTT_OFS_PRESCALE, 32'h0000_0001);
    bus(1'b1, PTT_OFS_RELOAD, 32'h0000_0003);
    bus(1'b1, PTT_OFS_CTRL, 32'h0000_0002);
    wait_p(2);
    repeat (12) @(posedge ref_clk);
    bus(1'b1, PTT_OFS_RELOAD, 32'h0000_0001);
    wait_p(1);
    `CHK(period, 32)
    wait_p(1);
    `CHK(period, 16)
    // interrupt: enable, mask, sticky status
    bus(1'b1, PTT_OFS_PRESCALE, 32'h0000_0000);
    bus(1'b1, PTT_OFS_RELOAD, 32'h0000_0028);
    bus(1'b1, PTT_OFS_IRQ_MASK, 32'h0000_0001);
    bus(1'b1, PTT_OFS_CTRL, 32'h0000_0005);
    bus(1'b1, PTT_OFS_IRQ_STAT, 32'h0000_0001);
    wait_p(1);
    repeat (3) @(posedge ref_clk);
    `CHK(tick_irq_line, 1'b1)
    rd(PTT_OFS_CTRL, 32'h0000_0005);
    bus(1'b1, PTT_OFS_IRQ_STAT, 32'h0000_0001);
    repeat (2) @(posedge ref_clk);
    `CHK(tick_irq_line, 1'b0)
    bus(1'b1, PTT_OFS_CTRL, 32'h0000_0004);
    rd(PTT_OFS_CTRL, 32'h0000_0000);
    wait_p(1);
    repeat (3) @(posedge ref_clk);
    `CHK(tick_irq_line, 1'b0)
    repeat (8) @(posedge ref_clk);
    rd(PTT_OFS_CTRL, 32'h0000_0004);
    bus(1'b1, PTT_OFS_CTRL, 32'h0000_0001);
    repeat (3) @(posedge ref_clk);
    `CHK(tick_irq_line, 1'b1)
    bus(1'b1, PTT_OFS_IRQ_MASK, 32'h0000_0000);
    repeat (2) @(posedge ref_clk);
    `CHK(tick_irq_line, 1'b0)
    // restart mid-count pushes the next hit out to a full reload
    bus(1'b1, PTT_OFS_PRESCALE, 32'h0000_0005);
    bus(1'b1, PTT_OFS_RELOAD, 32'h0000_0002);
    bus(1'b1, PTT_OFS_CTRL, 32'h0000_0002);
    wait_p(2);
    repeat (140) @(posedge ref_clk);
    bus(1'b1, PTT_OFS_CTRL, 32'h0000_0002);
    bus(1'b0, PTT_OFS_CTRL, '0);
    `CHK(q[1], 1'b1)
    rl = 0;
    do begin
      bus(1'b0, PTT_OFS_CTRL, '0);
      rl++;
    end while (q[1] !== 1'b0 && rl < 200);
    `CHK(q[1], 1'b0)
    wait_p(1);
    `CHK(period, 512)
    // lock holds until reset
    bus(1'b1, PTT_OFS_LOCK, 32'h0000_0001);
    bus(1'b1, PTT_OFS_RELOAD, 32'h0000_0005);
    bus(1'b1, PTT_OFS_PRESCALE, 32'h0000_0000);
    bus(1'b1, PTT_OFS_LOCK, 32'h0000_0000);
    rd(PTT_OFS_LOCK, 32'h0000_0001);
    rd(PTT_OFS_RELOAD, 32'h0000_0000);
    wait_p(2);
    `CHK(period, exp_period(2, 5))
    reset <= 1'b1;
    repeat (20) @(posedge ref_clk);
    reset <= 1'b0;
    rd(PTT_OFS_LOCK, 32'h0000_0000);
    rd(PTT_OFS_CTRL, 32'h0000_0000);
    `CHK(wake_bad, 0)
    final_report;
  end

  // a hung handshake or a missing pulse ends here
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    $display("Error t=%0t watchdog expired", $time);
    final_report;
  end
endmodule // tb_prescaled_periodic_tick_timer
